/* pkg/dfx_pkg.sv */
// Shared constants and carrier types for the doubleword field extract unit
package dfx_pkg;

  // ----------------------------------------------------------------
  // Datapath widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int INSTR_W = 32;
  localparam int REG_SEL_W = 5;
  localparam int POS_W = 6;

  // ----------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] EXTENDED_MAJOR_OPCODE = 6'h1F;
  localparam logic [5:0] FUNC_EXTRACT_MID = 6'h01;
  localparam logic [5:0] FUNC_EXTRACT_UPPER = 6'h02;

  // Offset added to the short field of the mid and upper forms
  localparam logic [POS_W-1:0] FIELD_OFFSET = 6'h20;

  // Field limit for the unpredictable test (low + top + 1 above this)
  localparam logic [POS_W:0] FIELD_LIMIT = 7'h40;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESULT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [REG_SEL_W-1:0] REG_SEL_RESET = 5'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Field layout of the instruction word, bit 31 first
  typedef struct packed {
    logic [5:0] major;
    logic [REG_SEL_W-1:0] sourceRegSel;
    logic [REG_SEL_W-1:0] destRegSel;
    logic [4:0] topField;
    logic [4:0] lowField;
    logic [5:0] func;
  } dfx_instr_type;

  // Write-back bundle handed to the general register file
  typedef struct packed {
    logic valid;
    logic [REG_SEL_W-1:0] destRegSel;
    logic [DATA_W-1:0] data;
  } dfx_wb_type;

  // Which extract form a word decodes to
  typedef enum logic [1:0] {
    OP_NONE,
    EXTRACT_LOW_OP,
    EXTRACT_MID_OP,
    EXTRACT_UPPER_OP
  } dfx_op_type;

endpackage

/* src/dfx_field_extract.sv */
// Combinational shift-and-mask core that pulls a field out of a doubleword
`timescale 1ns/10ps
`default_nettype none

module dfx_field_extract
(
  input wire logic [dfx_pkg::DATA_W-1:0] srcValue,
  input wire logic [dfx_pkg::POS_W-1:0] lowBit,
  input wire logic [dfx_pkg::POS_W-1:0] destTop,
  output logic [dfx_pkg::DATA_W-1:0] field,
  output logic unpredictable
);

  logic [dfx_pkg::DATA_W-1:0] shifted;
  logic [dfx_pkg::DATA_W-1:0] keepMask;
  logic [dfx_pkg::POS_W:0] fieldEnd;

  // ----------------------------------------------------------------
  // Right-justify and clear above the field
  // ----------------------------------------------------------------
  // Two shifts keep each amount below the width when the top index is 63
  always_comb
  begin
    shifted = srcValue >> lowBit;
    keepMask = ~(({dfx_pkg::DATA_W{1'b1}} << destTop) << 1);
    field = shifted & keepMask;
  end

  // ----------------------------------------------------------------
  // Field running past bit 63
  // ----------------------------------------------------------------
  // Data are still produced here; the value is simply not meaningful
  always_comb
  begin
    fieldEnd = {1'b0, lowBit} + {1'b0, destTop} + 7'h01;
    unpredictable = fieldEnd > dfx_pkg::FIELD_LIMIT;
  end

endmodule

`default_nettype wire

/* src/dfx_extract_unit.sv */
// Decode and execute stage for the doubleword bit-field extract forms
//
// Function
// - Mid form: major opcode 011111 with function code 000001.
// - Upper form: major opcode 011111 with function code 000010.
// - Source index from bits 25..21, destination index from bits 20..16.
// - Field is written right-justified with all higher bits zero.
// - Mid form: top index is bits 15..11 plus 32, low bit 10..6.
// - Upper form: low bit is bits 10..6 plus 32, top from 15..11.
// - Mid form: start 0..31, size 33..64, top index 32..63.
// - Upper form: start 32..63, size 1..32.
// - Plain form: start 0..31, size 1..32, top index below 63.
// - Low bit plus top index plus one above 64 gives no defined value.
// - Without release 2 support these words raise reserved instruction.
// - Plain form: top index from 15..11, low bit from 10..6, no offset.
`timescale 1ns/10ps
`default_nettype none

module dfx_extract_unit
#(
  // Function code of the plain extract form
  parameter logic [5:0] FUNC_EXTRACT_LOW = 6'h03
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic release2Strap,
  input wire logic issueValid,
  input wire logic [dfx_pkg::INSTR_W-1:0] instrWord,
  input wire logic [dfx_pkg::DATA_W-1:0] sourceValue,
  output logic issueReady,
  output logic claimed,
  output logic [dfx_pkg::REG_SEL_W-1:0] sourceRegSel,
  output dfx_pkg::dfx_wb_type wbOut,
  output logic reservedExc,
  output logic unpredictableOut,
  output dfx_pkg::dfx_op_type wbKind
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic rstIn_b;

  // Assert at once, release two edges after the pin goes high
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rstSync_q <= dfx_pkg::SYNC_RESET;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end

  assign rstIn_b = rstSync_q[1];

  // ----------------------------------------------------------------
  // Release strap capture
  // ----------------------------------------------------------------
  logic strapMeta_q;
  logic strapSync_q;
  logic strapDone_q;
  logic release2_q;

  // Two flops before the strap level is used
  always_ff @(posedge clk or negedge rstIn_b)
  begin
    if (!rstIn_b)
    begin
      strapMeta_q <= 1'b0;
      strapSync_q <= 1'b0;
    end
    else
    begin
      strapMeta_q <= release2Strap;
      strapSync_q <= strapMeta_q;
    end
  end

  // Strap is latched once, three edges after reset release
  logic [1:0] strapWait_q;

  always_ff @(posedge clk or negedge rstIn_b)
  begin
    if (!rstIn_b)
      strapWait_q <= dfx_pkg::SYNC_RESET;
    else if (!strapDone_q)
      strapWait_q <= {strapWait_q[0], 1'b1};
  end

  always_ff @(posedge clk or negedge rstIn_b)
  begin
    if (!rstIn_b)
    begin
      strapDone_q <= 1'b0;
      release2_q <= 1'b0;
    end
    else if (!strapDone_q && strapWait_q[1])
    begin
      strapDone_q <= 1'b1;
      release2_q <= strapSync_q;
    end
  end

  // Requests are ignored until the strap is known
  assign issueReady = strapDone_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  dfx_pkg::dfx_instr_type instr;
  dfx_pkg::dfx_op_type opKind;
  logic [dfx_pkg::POS_W-1:0] effLow;
  logic [dfx_pkg::POS_W-1:0] effTop;

  assign instr = dfx_pkg::dfx_instr_type'(instrWord);
  assign sourceRegSel = instr.sourceRegSel;

  // Separate the three extract forms on major opcode and function code
  always_comb
  begin
    opKind = dfx_pkg::OP_NONE;
    if (instr.major == dfx_pkg::EXTENDED_MAJOR_OPCODE)
    begin
      if (instr.func == dfx_pkg::FUNC_EXTRACT_MID)
        opKind = dfx_pkg::EXTRACT_MID_OP;
      else if (instr.func == dfx_pkg::FUNC_EXTRACT_UPPER)
        opKind = dfx_pkg::EXTRACT_UPPER_OP;
      else if (instr.func == FUNC_EXTRACT_LOW)
        opKind = dfx_pkg::EXTRACT_LOW_OP;
    end
  end

  assign claimed = issueValid && (opKind != dfx_pkg::OP_NONE);

  // Effective low bit and destination top index per form
  always_comb
  begin
    effLow = {1'b0, instr.lowField};
    effTop = {1'b0, instr.topField};
    unique case (opKind)
      dfx_pkg::OP_NONE:
      begin
        effLow = {1'b0, instr.lowField};
        effTop = {1'b0, instr.topField};
      end
      dfx_pkg::EXTRACT_LOW_OP:
      begin
        effLow = {1'b0, instr.lowField};
        effTop = {1'b0, instr.topField};
      end
      dfx_pkg::EXTRACT_MID_OP:
      begin
        effLow = {1'b0, instr.lowField};
        effTop = {1'b0, instr.topField} + dfx_pkg::FIELD_OFFSET;
      end
      dfx_pkg::EXTRACT_UPPER_OP:
      begin
        effLow = {1'b0, instr.lowField} + dfx_pkg::FIELD_OFFSET;
        effTop = {1'b0, instr.topField};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  logic [dfx_pkg::DATA_W-1:0] fieldValue;
  logic fieldUnpred;

  // Full 64-bit shift and mask in one cycle
  dfx_field_extract u_extract
  (
    .srcValue(sourceValue),
    .lowBit(effLow),
    .destTop(effTop),
    .field(fieldValue),
    .unpredictable(fieldUnpred)
  );

  logic take;
  logic legal;

  // An accepted word of ours either executes or traps, never both
  assign take = claimed && issueReady;
  assign legal = release2_q;

  // ----------------------------------------------------------------
  // Write-back registers
  // ----------------------------------------------------------------
  logic wbValid_q;
  logic [dfx_pkg::REG_SEL_W-1:0] wbSel_q;
  logic [dfx_pkg::DATA_W-1:0] wbData_q;

  // Valid and trap are one-cycle pulses in the cycle after acceptance
  always_ff @(posedge clk or negedge rstIn_b)
  begin
    if (!rstIn_b)
    begin
      wbValid_q <= 1'b0;
      reservedExc <= 1'b0;
    end
    else
    begin
      wbValid_q <= take && legal;
      reservedExc <= take && !legal;
    end
  end

  // Data and index load only when a result is produced
  always_ff @(posedge clk or negedge rstIn_b)
  begin
    if (!rstIn_b)
    begin
      wbSel_q <= dfx_pkg::REG_SEL_RESET;
      wbData_q <= dfx_pkg::RESULT_RESET;
      wbKind <= dfx_pkg::OP_NONE;
      unpredictableOut <= 1'b0;
    end
    else if (take && legal)
    begin
      wbSel_q <= instr.destRegSel;
      wbData_q <= fieldValue;
      wbKind <= opKind;
      unpredictableOut <= fieldUnpred;
    end
  end

  // Bundle the write-back registers so the struct has a single driver
  assign wbOut = '{valid: wbValid_q, destRegSel: wbSel_q, data: wbData_q};

endmodule

`default_nettype wire

/* verif/dfx_regfile_model.sv */
// Register file model that feeds and receives the extract unit
`timescale 1ns/10ps
`default_nettype none
module dfx_regfile_model
(
  input wire logic clk,
  input wire logic [4:0] readSel,
  input wire dfx_pkg::dfx_wb_type wbIn,
  output logic [63:0] readValue
);
  logic [63:0] regs [32];
  // Distinct, well spread contents in every register
  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = 64'h9E37_79B9_7F4A_7C15 * 64'(i + 1);
  end
  // Read port answers in the same cycle as the select
  assign readValue = regs[readSel];
  // Write-back of results
  always @(posedge clk)
    if (wbIn.valid) regs[wbIn.destRegSel] <= wbIn.data;
endmodule
`default_nettype wire

/* verif/dfx_extract_unit_asserts.sv */
// Assertion checker for the doubleword field extract unit
`timescale 1ns/10ps
`default_nettype none
module dfx_extract_unit_asserts
#(
  parameter logic [5:0] FUNC_EXTRACT_LOW = 6'h03
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic release2Strap,
  input wire logic issueValid,
  input wire logic [31:0] instrWord,
  input wire logic [63:0] sourceValue,
  input wire logic issueReady,
  input wire logic claimed,
  input wire logic [4:0] sourceRegSel,
  input wire dfx_pkg::dfx_wb_type wbOut,
  input wire logic reservedExc,
  input wire logic unpredictableOut,
  input wire dfx_pkg::dfx_op_type wbKind
);
  logic [5:0] fn;
  logic take;
  logic [5:0] effLow;
  logic [5:0] effTop;
  logic [63:0] expData;
  logic over;
  dfx_pkg::dfx_op_type kindExp;
  // Reference field bounds, result and form of the presented word
  always_comb
  begin
    fn = instrWord[5:0];
    take = issueValid && issueReady && claimed;
    effLow = {1'h0, instrWord[10:6]} | ((fn == 6'h02) ? 6'h20 : 6'h00);
    effTop = {1'h0, instrWord[15:11]} | ((fn == 6'h01) ? 6'h20 : 6'h00);
    expData = (sourceValue >> effLow) & (64'hFFFF_FFFF_FFFF_FFFF >> (6'h3F - effTop));
    over = (7'(effLow) + 7'(effTop) + 7'h01) > 7'h40;
    kindExp = (fn == 6'h01) ? dfx_pkg::EXTRACT_MID_OP
      : (fn == 6'h02) ? dfx_pkg::EXTRACT_UPPER_OP : dfx_pkg::EXTRACT_LOW_OP;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_sel_from_word:
  assert property (issueValid |-> sourceRegSel == instrWord[25:21]) else $error("bad select");
  a_decode_claim:
  assert property (claimed == (issueValid && instrWord[31:26] == 6'h1F
    && (fn == 6'h01 || fn == 6'h02 || fn == FUNC_EXTRACT_LOW))) else $error("bad claim");
  a_result_latency:
  assert property (take && release2Strap |=> wbOut.valid && !reservedExc)
    else $error("no write one cycle after issue");
  a_trap_instead:
  assert property (take && !release2Strap |=> reservedExc && !wbOut.valid && $stable(wbOut.data))
    else $error("no trap without release 2");
  a_no_stray:
  assert property (wbOut.valid || reservedExc |-> $past(take)) else $error("stray pulse");
  a_dest_index:
  assert property (take && release2Strap |=> wbOut.destRegSel == $past(instrWord[20:16]))
    else $error("bad destination");
  a_field_value:
  assert property (take && release2Strap |=> wbOut.data == $past(expData))
    else $error("bad field value");
  a_form_kind:
  assert property (take && release2Strap |=> wbKind == $past(kindExp)) else $error("bad form");
  a_overflow_flag:
  assert property (take && release2Strap |=> unpredictableOut == $past(over))
    else $error("bad overflow flag");
  a_data_holds:
  assert property (!wbOut.valid |-> $stable(wbOut.data)) else $error("data moved");
endmodule
bind dfx_extract_unit dfx_extract_unit_asserts #(.FUNC_EXTRACT_LOW(FUNC_EXTRACT_LOW)) u_chk
  (.clk(clk), .rst_b(rst_b), .release2Strap(release2Strap), .issueValid(issueValid),
  .instrWord(instrWord), .sourceValue(sourceValue), .issueReady(issueReady),
  .claimed(claimed), .sourceRegSel(sourceRegSel), .wbOut(wbOut), .reservedExc(reservedExc),
  .unpredictableOut(unpredictableOut), .wbKind(wbKind));
`default_nettype wire

/* verif/dfx_extract_unit_test.sv */
// Self-checking testbench for the doubleword field extract unit
`timescale 1ns/10ps
`default_nettype none
module dfx_extract_unit_test;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic release2Strap = 1'h1;
  logic issueValid = 1'h0;
  logic [31:0] instrWord = 32'h0000_0000;
  logic [63:0] sourceValue;
  logic issueReady;
  logic claimed;
  logic [4:0] sourceRegSel;
  dfx_pkg::dfx_wb_type wbOut;
  logic reservedExc;
  logic unpredictableOut;
  dfx_pkg::dfx_op_type wbKind;
  int fails = 0;
  int num_checks = 0;
  // Core clock, 20 ns period
  always #10 clk = ~clk;
  dfx_extract_unit u_dut (.clk(clk), .rst_b(rst_b), .release2Strap(release2Strap),
    .issueValid(issueValid), .instrWord(instrWord), .sourceValue(sourceValue),
    .issueReady(issueReady), .claimed(claimed), .sourceRegSel(sourceRegSel), .wbOut(wbOut),
    .reservedExc(reservedExc), .unpredictableOut(unpredictableOut), .wbKind(wbKind));
  dfx_regfile_model u_rf (.clk(clk), .readSel(sourceRegSel), .wbIn(wbOut),
    .readValue(sourceValue));
  // Compare and count
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("BAD %0t got %h want %h", $time, seen, exp);
      fails++;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Reset with a given strap, then wait a bounded time for readiness
  task do_reset(input logic strap);
    int n;
    n = 0;
    rst_b = 1'h0;
    release2Strap = strap;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'h1;
    while (issueReady !== 1'h1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 20)
    begin
      fails++;
      test_done();
    end
  endtask
  function automatic logic [31:0] mk(logic [5:0] f, logic [4:0] s, logic [4:0] t, logic [4:0] l);
    return {6'h1F, s, 5'h10 + s, t, l, f};
  endfunction
  function automatic logic [63:0] ext(logic [63:0] s, logic [5:0] l, logic [5:0] t);
    return (s >> l) & (64'hFFFF_FFFF_FFFF_FFFF >> (6'h3F - t));
  endfunction
  // Outputs are cleared by reset
  task t_reset;
    chk({wbOut.valid, reservedExc, unpredictableOut, wbOut.destRegSel}, 64'h0);
    chk(wbOut.data, 64'h0);
    chk(wbKind, dfx_pkg::OP_NONE);
  endtask
  // Each form at its limits, back to back; entry 2 overruns, others
  task automatic t_forms;
    logic [5:0] f [7] = '{6'h01, 6'h01, 6'h01, 6'h02, 6'h02, 6'h03, 6'h03};
    logic [4:0] tp [7] = '{5'h1F, 5'h00, 5'h1F, 5'h00, 5'h1F, 5'h1F, 5'h00};
    logic [4:0] lo [7] = '{5'h00, 5'h1F, 5'h05, 5'h1F, 5'h00, 5'h00, 5'h1F};
    logic [1:0] k [7] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
    logic [5:0] eLo;
    logic [5:0] eTp;
    logic [63:0] exp;
    for (int i = 0; i < 7; i++)
    begin
      instrWord = mk(f[i], 5'(i + 1), tp[i], lo[i]);
      issueValid = 1'h1;
      eLo = {1'h0, lo[i]} | ((f[i] == 6'h02) ? 6'h20 : 6'h00);
      eTp = {1'h0, tp[i]} | ((f[i] == 6'h01) ? 6'h20 : 6'h00);
      exp = ext(u_rf.regs[i + 1], eLo, eTp);
      #1 chk(claimed, 1'h1);
      @(posedge clk);
      #1 chk(wbOut.valid, 1'h1);
      chk(wbOut.data, exp);
      chk(wbOut.destRegSel, instrWord[20:16]);
      chk(wbKind, k[i]);
      chk(unpredictableOut, (7'(eLo) + 7'(eTp) + 7'h01) > 7'h40);
    end
    issueValid = 1'h0;
    @(posedge clk);
    #1 chk({wbOut.valid, reservedExc}, 2'h0);
    chk(wbOut.data, exp);
  endtask
  // Words of other formats are not taken
  task t_refuse;
    logic [31:0] w [2];
    w[0] = mk(6'h00, 5'h02, 5'h03, 5'h04);
    w[1] = mk(6'h01, 5'h02, 5'h03, 5'h04);
    w[1][31:26] = 6'h1E;
    for (int i = 0; i < 2; i++)
    begin
      instrWord = w[i];
      issueValid = 1'h1;
      #1 chk(claimed, 1'h0);
      @(posedge clk);
      #1 chk({wbOut.valid, reservedExc}, 2'h0);
    end
    issueValid = 1'h0;
  endtask
  // Without release 2 support the word traps for one cycle
  task t_trap;
    do_reset(1'h0);
    instrWord = mk(6'h01, 5'h03, 5'h02, 5'h01);
    issueValid = 1'h1;
    @(posedge clk);
    #1 issueValid = 1'h0;
    chk({reservedExc, wbOut.valid}, 2'h2);
    chk(wbOut.data, 64'h0);
    @(posedge clk);
    #1 chk(reservedExc, 1'h0);
  endtask
  initial
  begin
    do_reset(1'h1);
    t_reset();
    t_forms();
    t_refuse();
    t_trap();
    test_done();
  end
endmodule
`default_nettype wire
